// ### hw/calendar_clock_with_alarm.sv
// Calendar clock with alarm comparator, periodic pulses and a Wishbone slave.
// Assumes a classic Wishbone master on clk_i and a 32.768 kHz pin on osc_32k_i.
`timescale 1ns/1ps

// Behaviour
// - A one-second tick is divided from the low-speed input; time and calendar counting use it.
// - Clock and alarm banks share addresses; a page bit picks the bank.
// - Reset sets only page, adjust, irq enable, divider clear and masks.
// - Year is two BCD digits and wraps from 99 to 00.
// - Every year divisible by four is leap; no century exceptions.
// - Format bit in alarm month selects 12-hour at 0, 24-hour at 1.
// - Seconds adjust rounds to the nearest minute, within thirty seconds.
// - The 1 Hz event coincides with each second divider wrap to zero.
// - After a divider clear the first 1 Hz event is one second later.
// - Run enable 0 freezes time and carries, except a pending adjust; the divider keeps counting.
// - Page bit 1 routes shared accesses to the alarm bank.
// - With irq enable set, any event drives the interrupt low for one low-speed cycle.
// - Alarm minute, hour, date, weekday match pulses alarm pin and interrupt.
// - Alarm preset loads minute 00, hour 00, date 01, Sunday.
// - Alarm compare runs on low-speed ticks, so writes act a tick later.
// - Alarm off, 1 Hz unmasked, 16 Hz masked gives a pulse per second.
// - Alarm off, 1 Hz masked, 16 Hz unmasked gives sixteen pulses per second.
module calendar_clock_with_alarm #(
    parameter int unsigned LS_PER_SECOND = rtc_pkg::LS_FREQ_HZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_32k_i,
    input rtc_pkg::wb_req_t wb_req_i,
    output rtc_pkg::wb_rsp_t wb_rsp_o,
    output logic alarm_n_o,
    output logic rtc_irq_out_n_o
);
    typedef struct packed {
        rtc_pkg::time_t tm;
        rtc_pkg::alarm_t al;
        logic page;
        logic alarm_output_enable;
        logic clock_run_enable;
        logic adjust;
        logic rtc_irq_enable;
        logic one_hz_mask;
        logic sixteen_hz_mask;
        logic divider_clear;
        logic match_prev;
        logic pulse;
        logic ack;
        logic [31:0] rdat;
    } state_t;

    state_t q;
    state_t d;

    logic ls_tick;
    logic one_hz;
    logic sixteen_hz;
    logic bus_hit;
    logic bus_write;
    logic [7:0] word_adr;
    logic [7:0] wdat;
    logic alarm_match;
    logic any_event;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == rtc_pkg::BCD_DIGIT_MAX) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                            input logic [7:0] first);
        bcd_step = (v == last) ? first : bcd_inc(v);
    endfunction : bcd_step

    // Year mod 4 from BCD: (10*tens + units) mod 4 = (2*tens + units) mod 4
    function automatic logic is_leap(input logic [7:0] y);
        logic [1:0] r;
        r = {y[4], 1'b0} + y[1:0];
        is_leap = (r == 2'b00);
    endfunction : is_leap

    function automatic logic [7:0] month_last(input logic [7:0] m, input logic leap);
        if (m == rtc_pkg::MON_FEB) begin
            month_last = leap ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
        end else if (m == rtc_pkg::MON_APR || m == rtc_pkg::MON_JUN ||
                     m == rtc_pkg::MON_SEP || m == rtc_pkg::MON_NOV) begin
            month_last = rtc_pkg::DAYS_30;
        end else begin
            month_last = rtc_pkg::DAYS_31;
        end
    endfunction : month_last

    // Pin crossing; every low-speed event below is derived from this tick
    osc_edge_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .osc_i(osc_32k_i),
        .tick_o(ls_tick)
    );

    second_divider #(
        .LS_PER_SECOND(LS_PER_SECOND)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ls_tick_i(ls_tick),
        .clear_i(q.divider_clear),
        .one_hz_o(one_hz),
        .sixteen_hz_o(sixteen_hz)
    );

    assign bus_hit = wb_req_i.cyc && wb_req_i.stb;
    assign bus_write = bus_hit && q.ack && wb_req_i.we && wb_req_i.sel[0];
    assign word_adr = wb_req_i.adr & rtc_pkg::WORD_MASK;
    assign wdat = wb_req_i.dat[7:0];

    assign alarm_match = (q.al.min == q.tm.min) && (q.al.hour == q.tm.hour) &&
                         (q.al.date == q.tm.date) && (q.al.wday == q.tm.wday);

    // Alarm fires on the first low-speed tick of a match, not for the whole minute
    assign any_event = (q.alarm_output_enable && alarm_match && !q.match_prev) ||
                       (!q.one_hz_mask && one_hz) ||
                       (!q.sixteen_hz_mask && sixteen_hz);

    assign wb_rsp_o.ack = q.ack;
    assign wb_rsp_o.dat = q.rdat;
    assign alarm_n_o = !q.pulse;
    assign rtc_irq_out_n_o = !q.pulse;

    always_comb begin
        logic carry;
        logic wrap;
        d = q;
        carry = 1'b0;
        wrap = 1'b0;
        d.ack = 1'b0;
        d.divider_clear = 1'b0;

        // Compare and pulse advance on low-speed ticks only
        if (ls_tick) begin
            d.match_prev = alarm_match;
            d.pulse = any_event && q.rtc_irq_enable;
        end

        // Once-per-second update; adjust applies even while stopped
        if (one_hz) begin
            if (q.adjust) begin
                carry = (q.tm.sec >= rtc_pkg::ADJ_HALF);
                d.tm.sec = rtc_pkg::BCD_ZERO;
                d.adjust = 1'b0;
            end else if (q.clock_run_enable) begin
                carry = (q.tm.sec == rtc_pkg::SEC_LAST);
                d.tm.sec = bcd_step(q.tm.sec, rtc_pkg::SEC_LAST, rtc_pkg::BCD_ZERO);
            end
        end

        if (carry) begin
            d.tm.min = bcd_step(q.tm.min, rtc_pkg::MIN_LAST, rtc_pkg::BCD_ZERO);
            if (q.tm.min == rtc_pkg::MIN_LAST) begin
                if (q.al.fmt24) begin
                    wrap = (q.tm.hour == rtc_pkg::HOUR24_LAST);
                    d.tm.hour = bcd_step(q.tm.hour, rtc_pkg::HOUR24_LAST, rtc_pkg::BCD_ZERO);
                end else if (q.tm.hour[4:0] == rtc_pkg::HOUR12_LAST) begin
                    wrap = q.tm.hour[rtc_pkg::HOUR_PM_BIT];
                    d.tm.hour = rtc_pkg::BCD_ZERO;
                    d.tm.hour[rtc_pkg::HOUR_PM_BIT] = !q.tm.hour[rtc_pkg::HOUR_PM_BIT];
                end else begin
                    d.tm.hour = bcd_inc(q.tm.hour);
                end
            end
        end

        if (wrap) begin
            d.tm.wday = bcd_step(q.tm.wday, rtc_pkg::WDAY_LAST, rtc_pkg::BCD_ZERO);
            d.tm.date = bcd_step(q.tm.date, month_last(q.tm.month, is_leap(q.tm.year)),
                                 rtc_pkg::DATE_FIRST);
            if (q.tm.date == month_last(q.tm.month, is_leap(q.tm.year))) begin
                d.tm.month = bcd_step(q.tm.month, rtc_pkg::MONTH_LAST, rtc_pkg::MONTH_FIRST);
                if (q.tm.month == rtc_pkg::MONTH_LAST) begin
                    d.tm.year = bcd_step(q.tm.year, rtc_pkg::YEAR_LAST, rtc_pkg::BCD_ZERO);
                end
            end
        end

        // Read data is loaded in the request cycle and stands with ack
        if (bus_hit && !q.ack) begin
            d.ack = 1'b1;
            d.rdat = '0;
            if (word_adr == rtc_pkg::OFS_SEC) begin
                d.rdat[7:0] = q.page ? rtc_pkg::BCD_ZERO : q.tm.sec;
            end else if (word_adr == rtc_pkg::OFS_MIN) begin
                d.rdat[7:0] = q.page ? q.al.min : q.tm.min;
            end else if (word_adr == rtc_pkg::OFS_HOUR) begin
                d.rdat[7:0] = q.page ? q.al.hour : q.tm.hour;
            end else if (word_adr == rtc_pkg::OFS_WDAY) begin
                d.rdat[7:0] = q.page ? q.al.wday : q.tm.wday;
            end else if (word_adr == rtc_pkg::OFS_DATE) begin
                d.rdat[7:0] = q.page ? q.al.date : q.tm.date;
            end else if (word_adr == rtc_pkg::OFS_MONTH) begin
                if (q.page) begin
                    d.rdat[rtc_pkg::MO_FMT24] = q.al.fmt24;
                end else begin
                    d.rdat[7:0] = q.tm.month;
                end
            end else if (word_adr == rtc_pkg::OFS_YEAR) begin
                if (q.page) begin
                    d.rdat[rtc_pkg::YR_LEAP] = is_leap(q.tm.year);
                end else begin
                    d.rdat[7:0] = q.tm.year;
                end
            end else if (word_adr == rtc_pkg::OFS_PAGE) begin
                d.rdat[rtc_pkg::PG_PAGE] = q.page;
                d.rdat[rtc_pkg::PG_ALM_EN] = q.alarm_output_enable;
                d.rdat[rtc_pkg::PG_RUN] = q.clock_run_enable;
                d.rdat[rtc_pkg::PG_ADJ] = q.adjust;
                d.rdat[rtc_pkg::PG_IRQ_EN] = q.rtc_irq_enable;
            end else if (word_adr == rtc_pkg::OFS_RESET) begin
                d.rdat[rtc_pkg::RS_DIVCLR] = q.divider_clear;
                d.rdat[rtc_pkg::RS_MASK1] = q.one_hz_mask;
                d.rdat[rtc_pkg::RS_MASK16] = q.sixteen_hz_mask;
            end
        end

        // Writes land at the edge where ack is high and override same-cycle counting
        if (bus_write) begin
            if (word_adr == rtc_pkg::OFS_SEC) begin
                if (!q.page) begin
                    d.tm.sec = wdat;
                end
            end else if (word_adr == rtc_pkg::OFS_MIN) begin
                if (q.page) begin
                    d.al.min = wdat;
                end else begin
                    d.tm.min = wdat;
                end
            end else if (word_adr == rtc_pkg::OFS_HOUR) begin
                if (q.page) begin
                    d.al.hour = wdat;
                end else begin
                    d.tm.hour = wdat;
                end
            end else if (word_adr == rtc_pkg::OFS_WDAY) begin
                if (q.page) begin
                    d.al.wday = wdat;
                end else begin
                    d.tm.wday = wdat;
                end
            end else if (word_adr == rtc_pkg::OFS_DATE) begin
                if (q.page) begin
                    d.al.date = wdat;
                end else begin
                    d.tm.date = wdat;
                end
            end else if (word_adr == rtc_pkg::OFS_MONTH) begin
                if (q.page) begin
                    d.al.fmt24 = wdat[rtc_pkg::MO_FMT24];
                end else begin
                    d.tm.month = wdat;
                end
            end else if (word_adr == rtc_pkg::OFS_YEAR) begin
                if (!q.page) begin
                    d.tm.year = wdat;
                end
            end else if (word_adr == rtc_pkg::OFS_PAGE) begin
                d.page = wdat[rtc_pkg::PG_PAGE];
                d.alarm_output_enable = wdat[rtc_pkg::PG_ALM_EN];
                d.clock_run_enable = wdat[rtc_pkg::PG_RUN];
                // A new request beats the self-clear in the same cycle
                d.adjust = wdat[rtc_pkg::PG_ADJ] || d.adjust;
                d.rtc_irq_enable = wdat[rtc_pkg::PG_IRQ_EN];
            end else if (word_adr == rtc_pkg::OFS_RESET) begin
                if (wdat[rtc_pkg::RS_PRESET]) begin
                    d.al.min = rtc_pkg::ALM_MIN_INIT;
                    d.al.hour = rtc_pkg::ALM_HOUR_INIT;
                    d.al.date = rtc_pkg::ALM_DATE_INIT;
                    d.al.wday = rtc_pkg::ALM_WDAY_INIT;
                end
                d.divider_clear = wdat[rtc_pkg::RS_DIVCLR];
                d.one_hz_mask = wdat[rtc_pkg::RS_MASK1];
                d.sixteen_hz_mask = wdat[rtc_pkg::RS_MASK16];
            end
        end

        // Time, calendar, alarm values and the two enables survive reset
        if (rst_i) begin
            d.page = rtc_pkg::PAGE_RST;
            d.adjust = rtc_pkg::ADJ_RST;
            d.rtc_irq_enable = rtc_pkg::IRQ_EN_RST;
            d.divider_clear = rtc_pkg::DIVCLR_RST;
            d.one_hz_mask = rtc_pkg::MASK1_RST;
            d.sixteen_hz_mask = rtc_pkg::MASK16_RST;
            d.match_prev = 1'b0;
            d.pulse = 1'b0;
            d.ack = 1'b0;
            d.rdat = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end
endmodule : calendar_clock_with_alarm

// ### pkg/rtc_pkg.sv
// Constants, register map and carrier types for the calendar clock block.
// Assumes a 50 MHz system clock and a free-running 32.768 kHz low-speed input.
package rtc_pkg;

    // Low-speed oscillator rate and the sub-second event rate
    localparam int unsigned LS_FREQ_HZ = 32768;
    localparam int unsigned SUBSECOND_RATE = 16;
    localparam int unsigned SYS_CLK_HZ = 50000000;
    localparam int unsigned DIV_W = 16;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_SEC = 8'h00;
    localparam logic [7:0] OFS_MIN = 8'h04;
    localparam logic [7:0] OFS_HOUR = 8'h08;
    localparam logic [7:0] OFS_WDAY = 8'h0c;
    localparam logic [7:0] OFS_DATE = 8'h10;
    localparam logic [7:0] OFS_MONTH = 8'h14;
    localparam logic [7:0] OFS_YEAR = 8'h18;
    localparam logic [7:0] OFS_PAGE = 8'h1c;
    localparam logic [7:0] OFS_RESET = 8'h20;
    localparam logic [7:0] WORD_MASK = 8'hfc;

    // page_control_reg fields
    localparam int PG_PAGE = 0;
    localparam int PG_ALM_EN = 2;
    localparam int PG_RUN = 3;
    localparam int PG_ADJ = 4;
    localparam int PG_IRQ_EN = 7;

    // reset_control_reg fields
    localparam int RS_PRESET = 0;
    localparam int RS_DIVCLR = 1;
    localparam int RS_MASK1 = 2;
    localparam int RS_MASK16 = 3;

    // month_reg of the alarm bank, year of the alarm bank
    localparam int MO_FMT24 = 0;
    localparam int YR_LEAP = 0;
    localparam int HOUR_PM_BIT = 5;

    // Reset values of the control bits
    localparam logic PAGE_RST = 1'b0;
    localparam logic ADJ_RST = 1'b0;
    localparam logic IRQ_EN_RST = 1'b0;
    localparam logic MASK1_RST = 1'b1;
    localparam logic MASK16_RST = 1'b1;
    localparam logic DIVCLR_RST = 1'b0;

    // BCD limits
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HOUR24_LAST = 8'h23;
    localparam logic [4:0] HOUR12_LAST = 5'h11;
    localparam logic [7:0] WDAY_LAST = 8'h06;
    localparam logic [7:0] DATE_FIRST = 8'h01;
    localparam logic [7:0] MONTH_FIRST = 8'h01;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] ADJ_HALF = 8'h30;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] MON_APR = 8'h04;
    localparam logic [7:0] MON_JUN = 8'h06;
    localparam logic [7:0] MON_SEP = 8'h09;
    localparam logic [7:0] MON_NOV = 8'h11;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;

    // Alarm preset values, weekday 0 is Sunday
    localparam logic [7:0] ALM_MIN_INIT = 8'h00;
    localparam logic [7:0] ALM_HOUR_INIT = 8'h00;
    localparam logic [7:0] ALM_DATE_INIT = 8'h01;
    localparam logic [7:0] ALM_WDAY_INIT = 8'h00;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } time_t;

    typedef struct packed {
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] date;
        logic fmt24;
    } alarm_t;

endpackage : rtc_pkg

// ### hw/osc_edge_sync.sv
// Three-stage synchroniser and rising-edge detector for the low-speed clock pin.
// Assumes the pin is far slower than clk_i; one tick per accepted rising level.
`timescale 1ns/1ps
module osc_edge_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_i,
    output logic tick_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_t;

    sync_t q;
    sync_t d;

    // A change counts only once stages two and three agree
    assign tick_o = (q.s2 == q.s3) && q.s3 && !q.level;

    always_comb begin
        d = q;
        d.s1 = osc_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.level = q.s3;
        end
        if (rst_i) begin
            d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end
endmodule : osc_edge_sync

// ### hw/second_divider.sv
// Second divider: counts low-speed ticks, gives one-cycle 1 Hz and 16 Hz events.
// Assumes ls_tick_i is a single clk_i pulse per low-speed clock period.
`timescale 1ns/1ps
module second_divider #(
    parameter int unsigned LS_PER_SECOND = rtc_pkg::LS_FREQ_HZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ls_tick_i,
    input wire logic clear_i,
    output logic one_hz_o,
    output logic sixteen_hz_o
);
    localparam int unsigned PER16 = LS_PER_SECOND / rtc_pkg::SUBSECOND_RATE;
    localparam logic [rtc_pkg::DIV_W-1:0] SEC_END = rtc_pkg::DIV_W'(LS_PER_SECOND - 1);
    localparam logic [rtc_pkg::DIV_W-1:0] SUB_END = rtc_pkg::DIV_W'(PER16 - 1);
    localparam logic [rtc_pkg::DIV_W-1:0] ONE = rtc_pkg::DIV_W'(1);

    typedef struct packed {
        logic [rtc_pkg::DIV_W-1:0] sec_cnt;
        logic [rtc_pkg::DIV_W-1:0] sub_cnt;
    } div_t;

    div_t q;
    div_t d;

    // After a clear the first second event comes a full second later
    assign one_hz_o = ls_tick_i && !clear_i && (q.sec_cnt == SEC_END);
    assign sixteen_hz_o = ls_tick_i && !clear_i && (q.sub_cnt == SUB_END);

    always_comb begin
        d = q;
        if (ls_tick_i) begin
            d.sec_cnt = (q.sec_cnt == SEC_END) ? '0 : q.sec_cnt + ONE;
            d.sub_cnt = (q.sub_cnt == SUB_END) ? '0 : q.sub_cnt + ONE;
        end
        if (rst_i || clear_i) begin
            d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end
endmodule : second_divider

// ### verif/osc_source.sv
// Free-running stand-in for the low-speed crystal.
// Assumes a 20 ns system clock; period shortened to 16 system cycles.
`timescale 1ns/1ps
module osc_source #(
    parameter int HALF_NS = 160
) (
    output logic osc_o
);
    initial begin
        osc_o = 1'b0;
        forever #HALF_NS osc_o = ~osc_o;
    end
endmodule : osc_source

// ### verif/rtc_monitor.sv
// Port-level checker for the calendar clock, bound to its top module.
// Assumes classic single-cycle Wishbone masters that drop cyc between cycles.
`timescale 1ns/1ps
module rtc_monitor #(
    parameter int unsigned LS_PER_SECOND = rtc_pkg::LS_FREQ_HZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_32k_i,
    input rtc_pkg::wb_req_t wb_req_i,
    input rtc_pkg::wb_rsp_t wb_rsp_o,
    input wire logic alarm_n_o,
    input wire logic rtc_irq_out_n_o
);
    logic req;
    assign req = wb_req_i.cyc && wb_req_i.stb;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_latency_a: assert property ($rose(req) |=> wb_rsp_o.ack)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!req |=> !wb_rsp_o.ack)
        else $error("ack without request");
    read_upper_a: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0)
        else $error("upper read bits set");
    unmapped_zero_a: assert property ($past(req && !wb_req_i.we && wb_req_i.adr > 8'h23)
        && wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0) else $error("unmapped read not zero");
    pins_equal_a: assert property (alarm_n_o == rtc_irq_out_n_o)
        else $error("alarm and irq pins differ");
    pulse_width_a: assert property ($fell(alarm_n_o) |->
        (!alarm_n_o)[*8] ##[1:10] alarm_n_o) else $error("pulse not one slow period");
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> alarm_n_o && !wb_rsp_o.ack) else $error("outputs active after reset");
    cover property ($fell(alarm_n_o));
    cover property (wb_rsp_o.ack && wb_req_i.we);
    cover property (wb_rsp_o.ack && !wb_req_i.we);
endmodule : rtc_monitor

bind calendar_clock_with_alarm rtc_monitor #(.LS_PER_SECOND(LS_PER_SECOND)) rtc_monitor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .osc_32k_i(osc_32k_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .alarm_n_o(alarm_n_o), .rtc_irq_out_n_o(rtc_irq_out_n_o));

// ### verif/testbench.sv
// Self-checking bench: Wishbone register calls, pulses timed at the alarm pin.
// Assumes 64 slow ticks per second and a slow clock of 16 system cycles.
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic osc;
    rtc_pkg::wb_req_t req = '0;
    rtc_pkg::wb_rsp_t rsp;
    logic alarm_n;
    logic irq_n;
    logic [7:0] q;
    int n;
    int checks = 0;
    int failures = 0;
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    osc_source osc_source_inst (.osc_o(osc));
    calendar_clock_with_alarm #(.LS_PER_SECOND(64)) calendar_clock_with_alarm_inst (
        .clk_i(clk_i), .rst_i(rst_i), .osc_32k_i(osc), .wb_req_i(req), .wb_rsp_o(rsp),
        .alarm_n_o(alarm_n), .rtc_irq_out_n_o(irq_n));
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: {24'h0, d}};
        @(posedge clk_i);
        while (rsp.ack !== 1'b1) @(posedge clk_i);
        q = rsp.dat[7:0];
        req <= '0;
        @(posedge clk_i);
    endtask : wb
    task automatic pg(input logic [7:0] d);
        wb(1'b1, rtc_pkg::OFS_PAGE, d);
    endtask : pg
    task automatic rs(input logic [7:0] d);
        wb(1'b1, rtc_pkg::OFS_RESET, d);
    endtask : rs
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic rng(input int lo, input int hi);
        checks++;
        if (n < lo || n > hi) begin
            failures++;
            $display("ERROR %0t span %0d", $time, n);
        end
    endtask : rng
    // Counts cycles up to the next falling pulse, then lets it end
    task automatic waitp;
        n = 0;
        while (alarm_n !== 1'b0) begin
            @(posedge clk_i);
            n++;
        end
        chk({7'h00, irq_n}, 8'h00);
        while (alarm_n === 1'b0) @(posedge clk_i);
    endtask : waitp
    task automatic settime(input logic [55:0] t);
        for (int i = 0; i < 7; i++) wb(1'b1, 8'(4 * i), t[55 - 8 * i -: 8]);
    endtask : settime
    // Read just after a pulse, so no carry is in flight; each field read twice
    task automatic chktime(input logic [55:0] t);
        for (int i = 0; i < 7; i++) begin
            repeat (2) begin
                wb(1'b0, 8'(4 * i), 8'h00);
                chk(q, t[55 - 8 * i -: 8]);
            end
        end
    endtask : chktime
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, rtc_pkg::OFS_PAGE, 8'h00);
        chk(q & 8'h91, 8'h00);
        wb(1'b0, rtc_pkg::OFS_RESET, 8'h00);
        chk(q & 8'h0c, 8'h0c);
        wb(1'b0, 8'h24, 8'h00);
        chk(q, 8'h00);
        $display("test reset done");
        rs(8'h0d);
        pg(8'h01);
        wb(1'b1, rtc_pkg::OFS_MONTH, 8'h01);
        for (int i = 1; i < 5; i++) begin
            wb(1'b0, 8'(4 * i), 8'h00);
            chk(q, (i == 4) ? 8'h01 : 8'h00);
        end
        pg(8'h00);
        settime(56'h59_59_23_06_31_12_99);
        pg(8'h0c);
        rs(8'h0e);
        pg(8'h8c);
        waitp;
        // One second after the clear, plus one slow tick of compare lag
        rng(1023, 1038);
        chktime(56'h00_00_00_00_01_01_00);
        $display("test alarm done");
        pg(8'h0c);
        pg(8'h01);
        wb(1'b1, rtc_pkg::OFS_MONTH, 8'h00);
        pg(8'h00);
        settime(56'h59_59_31_03_28_02_04);
        pg(8'h08);
        rs(8'h0a);
        pg(8'h88);
        waitp;
        rng(1007, 1022);
        chktime(56'h00_00_00_04_29_02_04);
        pg(8'h89);
        wb(1'b0, rtc_pkg::OFS_YEAR, 8'h00);
        chk(q & 8'h01, 8'h01);
        $display("test leap done");
        pg(8'h08);
        settime(56'h45_10_05_04_29_02_04);
        pg(8'h18);
        wb(1'b0, rtc_pkg::OFS_PAGE, 8'h00);
        chk(q & 8'h10, 8'h10);
        rs(8'h0a);
        pg(8'h98);
        waitp;
        wb(1'b0, rtc_pkg::OFS_SEC, 8'h00);
        chk(q, 8'h00);
        wb(1'b0, rtc_pkg::OFS_MIN, 8'h00);
        chk(q, 8'h11);
        wb(1'b0, rtc_pkg::OFS_PAGE, 8'h00);
        chk(q & 8'h10, 8'h00);
        $display("test adjust done");
        pg(8'h08);
        pg(8'h00);
        pg(8'h80);
        waitp;
        waitp;
        rng(1005, 1011);
        wb(1'b0, rtc_pkg::OFS_SEC, 8'h00);
        chk(q, 8'h00);
        wb(1'b0, rtc_pkg::OFS_MIN, 8'h00);
        chk(q, 8'h11);
        $display("test stop done");
        rs(8'h04);
        waitp;
        waitp;
        rng(45, 51);
        $display("test sixteen done");
        // Mid-run reset keeps the time but restores page, adjust, irq enable and the masks
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, rtc_pkg::OFS_MIN, 8'h00);
        chk(q, 8'h11);
        wb(1'b0, rtc_pkg::OFS_PAGE, 8'h00);
        chk(q & 8'h91, 8'h00);
        wb(1'b0, rtc_pkg::OFS_RESET, 8'h00);
        chk(q & 8'h0c, 8'h0c);
        $display("test rerun done");
        stop_test;
    end
endmodule : testbench
